/* File: rtl/sbr_pkg.sv */
// package for the standby release and reset controller
// assumes one 100 MHz clock and an apb register port
package sbr_pkg;
  // clock rate
  localparam int unsigned CLK_HZ = 100_000_000;
  // least low time of the reset pin, microseconds
  localparam int unsigned RST_MIN_US = 10;
  // cycles of that time, clock rate truncated to whole MHz
  localparam int unsigned RST_MIN_CYC =
    (RST_MIN_US * (CLK_HZ / 1_000_000));
  // settle waits as main-clock periods
  localparam int unsigned SETTLE_12 = 4096;
  localparam int unsigned SETTLE_15 = 32768;
  localparam int unsigned SETTLE_17 = 131072;
  // settle select codes
  localparam logic [2:0] SEL_12 = 3'h0;
  localparam logic [2:0] SEL_15 = 3'h2;
  localparam logic [2:0] SEL_17 = 3'h4;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SETTLE = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_VECTOR = 8'h0c;
  localparam logic [7:0] OFF_PSW = 8'h10;
  localparam logic [7:0] OFF_CLK = 8'h14;
  localparam logic [7:0] OFF_WTIMER = 8'h18;
  localparam logic [7:0] OFF_SERIAL = 8'h1c;
  localparam logic [7:0] OFF_ADC = 8'h20;
  localparam logic [7:0] OFF_PORT = 8'h24;
  // reset values
  localparam logic [7:0] PSW_RST = 8'h02;
  localparam logic [7:0] CPU_CLK_RST = 8'h02;
  localparam logic [2:0] SETTLE_SEL_RST = 3'h4;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [7:0] ONES8 = 8'hff;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] ONES16 = 16'hffff;
  // control bit positions
  localparam int unsigned CTRL_HALT = 0;
  localparam int unsigned CTRL_STOP = 1;
  // operating states
  typedef enum logic [2:0] {
    SBR_RESET, SBR_SETTLE_RST, SBR_RUN, SBR_HALT,
    SBR_STOP, SBR_SETTLE_WAKE
  } sbr_state_t;
  // wake action to cpu
  typedef enum logic [1:0] {
    SBR_ACT_NONE, SBR_ACT_NEXT, SBR_ACT_SERVICE, SBR_ACT_VECTOR
  } sbr_act_t;
  // reset values of peripheral registers, grouped
  typedef struct packed {
    logic [7:0] processor_status_word;
    logic [7:0] cpu_clock_control;
    logic [7:0] sub_oscillator_mode;
    logic [7:0] subclock_control;
    logic [2:0] osc_settle_select;
    logic [15:0] wide_timer_count;
    logic [15:0] wide_timer_compare;
    logic [7:0] narrow_timer_count;
    logic [7:0] timer_control;
    logic [7:0] watch_control;
    logic [7:0] watchdog_control;
    logic [7:0] serial_mode;
    logic [7:0] serial_status;
    logic [7:0] serial_baud;
    logic [7:0] serial_tx_shifter;
    logic [15:0] adc_result;
    logic [7:0] adc_mode_reg;
    logic [7:0] adc_channel_select;
    logic [7:0] port_latch;
    logic [7:0] port_direction_reg;
    logic [7:0] port_pullup_option;
  } sbr_regs_t;
endpackage : sbr_pkg

/* File: rtl/sbr_ctrl.sv */
// standby release and system reset sequencer with apb registers
// assumes pclk at 100 MHz; reset pin and watchdog are asynchronous
//
// Operation
// - reset pin in halt runs normal reset
// - halt wake follows mask and enable flags
// - stop halts oscillator, cpu, keeps ports
// - stop with pending wake goes halt, settles
// - stop wake waits settle then service/next
// - masked request keeps stop; reset resets
// - reset pin ends stop after settle
// - pin low and watchdog reset act alike
// - after reset fetch vector at 0000/0001
// - pins float in reset and in settle waits started by reset
// - pin high clears reset, settle, run
// - watchdog reset self clears, settle, run
// - stop reset keeps state, ports float
// - status word resets to 02
// - ports latch 00, direction ff, pullup 00
// - clock 02, settle select 04, sub 00
// - wide timer 0000/ffff, narrow cleared
// - watch, serial 00, tx shifter ff
// - adc result and mode cleared
// - halt stops cpu, oscillator runs
// - settle after reset is 2^15 periods
// - settle codes 000,010,100 map waits
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module sbr_ctrl
  import sbr_pkg::*;
#(
  parameter int unsigned NSRC = 8,
  parameter int unsigned SETTLE_CYC_12 = SETTLE_12,
  parameter int unsigned SETTLE_CYC_15 = SETTLE_15,
  parameter int unsigned SETTLE_CYC_17 = SETTLE_17,
  parameter int unsigned RST_PIN_CYC = RST_MIN_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_pin_n,
  input wire logic watchdog_overflow,
  input wire logic [NSRC-1:0] irq_request,
  input wire logic [NSRC-1:0] interrupt_mask_flag,
  input wire logic global_interrupt_enable,
  input wire logic nmi_request,
  input wire logic halt_exec,
  input wire logic stop_exec,
  output logic cpu_run,
  output logic osc_enable,
  output logic pins_hiz,
  output logic sys_reset,
  output logic [1:0] wake_action,
  output logic [15:0] vector_addr,
  output logic [7:0] port_latch_out
);
  // synchronisers for asynchronous reset sources
  // only the second stage of each pair feeds any logic
  logic pin_s1, pin_s2, wdt_s1, wdt_s2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      wdt_s1 <= 1'b0;
      wdt_s2 <= 1'b0;
    end else begin
      pin_s1 <= reset_pin_n;
      pin_s2 <= pin_s1;
      wdt_s1 <= watchdog_overflow;
      wdt_s2 <= wdt_s1;
    end
  end

  // low-time filter: pin reset only after the minimum low time
  // starts asserted so the first run waits until the pin reads high
  logic [15:0] low_cnt; // cycles pin has been low
  logic pin_rst; // qualified pin reset level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt <= 16'h0000;
      pin_rst <= 1'b1;
    end else if (pin_s2) begin
      low_cnt <= 16'h0000;
      pin_rst <= 1'b0;
    end else if (low_cnt >= 16'(RST_PIN_CYC - 1)) begin
      pin_rst <= 1'b1;
    end else begin
      low_cnt <= low_cnt + 16'h0001;
    end
  end

  // both sources give one reset request
  logic any_rst;
  assign any_rst = pin_rst | wdt_s2;

  // wake terms
  logic wake_mask; // unmasked maskable request
  assign wake_mask = |(irq_request & ~interrupt_mask_flag);
  // nmi is only a wake source in halt, see the halt branch

  // registers
  sbr_regs_t regs;
  sbr_state_t state;
  logic was_stop; // reset arrived during stop
  logic [17:0] settle_cnt; // settle counter
  logic [17:0] settle_tgt; // selected settle length
  logic wake_by_rst; // stop ended by reset pin or watchdog

  // settle length from select code
  // prohibited codes fall back to the longest wait, the safe side
  always_comb begin
    case (regs.osc_settle_select)
      SEL_12: settle_tgt = 18'(SETTLE_CYC_12);
      SEL_15: settle_tgt = 18'(SETTLE_CYC_15);
      SEL_17: settle_tgt = 18'(SETTLE_CYC_17);
      default: settle_tgt = 18'(SETTLE_CYC_17); // prohibited code
    endcase
  end

  logic settle_done;
  logic [17:0] rst_tgt;
  // the wait straight after reset ignores the select register
  assign rst_tgt = 18'(SETTLE_CYC_15);
  assign settle_done = (state == SBR_SETTLE_RST) ?
    (settle_cnt >= rst_tgt - 18'h1) : (settle_cnt >= settle_tgt - 18'h1);

  // main sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SBR_RESET;
      was_stop <= 1'b0;
      wake_by_rst <= 1'b0;
      settle_cnt <= 18'h0;
      wake_action <= 2'h0;
    end else begin
      wake_action <= SBR_ACT_NONE;
      case (state)
        // hold here while any reset source is active
        SBR_RESET: begin
          settle_cnt <= 18'h0;
          if (!any_rst) state <= SBR_SETTLE_RST;
        end
        // post-reset settle, pins still floating
        SBR_SETTLE_RST: begin
          settle_cnt <= settle_cnt + 18'h1;
          if (any_rst) begin
            state <= SBR_RESET;
          end else if (settle_done) begin
            state <= SBR_RUN;
            was_stop <= 1'b0;
            wake_action <= SBR_ACT_VECTOR;
          end
        end
        // stop with a pending unmasked request skips stop and waits the settle count
        SBR_RUN: begin
          settle_cnt <= 18'h0;
          if (any_rst) begin
            state <= SBR_RESET;
          end else if (stop_exec) begin
            if (wake_mask) state <= SBR_SETTLE_WAKE;
            else state <= SBR_STOP;
          end else if (halt_exec) begin
            state <= SBR_HALT;
          end
        end
        // oscillator keeps running; masked requests are ignored
        SBR_HALT: begin
          if (any_rst) begin
            state <= SBR_RESET;
          end else if (nmi_request) begin
            state <= SBR_RUN;
            wake_action <= SBR_ACT_SERVICE;
          end else if (wake_mask) begin
            state <= SBR_RUN;
            wake_action <= global_interrupt_enable ?
              SBR_ACT_SERVICE : SBR_ACT_NEXT;
          end
        end
        // oscillator off; only reset or an unmasked request wakes
        SBR_STOP: begin
          settle_cnt <= 18'h0;
          if (any_rst) begin
            state <= SBR_SETTLE_WAKE;
            wake_by_rst <= 1'b1;
            was_stop <= 1'b1;
          end else if (wake_mask) begin
            state <= SBR_SETTLE_WAKE;
            wake_by_rst <= 1'b0;
          end
        end
        // oscillator restarted; cpu stalled until the count ends
        SBR_SETTLE_WAKE: begin
          settle_cnt <= settle_cnt + 18'h1;
          if (!wake_by_rst && any_rst) begin
            state <= SBR_RESET;
          end else if (settle_done) begin
            settle_cnt <= 18'h0;
            wake_by_rst <= 1'b0;
            if (wake_by_rst) begin
              state <= SBR_RESET;
            end else begin
              state <= SBR_RUN;
              wake_action <= global_interrupt_enable ?
                SBR_ACT_SERVICE : SBR_ACT_NEXT;
            end
          end
        end
        default: state <= SBR_RESET;
      endcase
    end
  end

  // cpu, oscillator, pin and reset outputs, registered
  // every output is a flop so nothing glitches at the boundary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_run <= 1'b0;
      osc_enable <= 1'b1;
      pins_hiz <= 1'b1;
      sys_reset <= 1'b1;
      vector_addr <= 16'h0000;
    end else begin
      cpu_run <= (state == SBR_RUN);
      osc_enable <= (state != SBR_STOP);
      pins_hiz <= (state == SBR_RESET) ||
        (state == SBR_SETTLE_RST) ||
        (state == SBR_SETTLE_WAKE && wake_by_rst);
      sys_reset <= (state == SBR_RESET) || (state == SBR_SETTLE_RST);
      vector_addr <= 16'h0000;
    end
  end

  // apb write decode
  logic wr_en;
  assign wr_en = psel & penable & pwrite;
  logic in_reset;
  assign in_reset = (state == SBR_RESET) && !was_stop;

  // register file with documented reset values
  // ordinary reset reloads; a reset that ends stop keeps contents
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regs.processor_status_word <= PSW_RST;
      regs.cpu_clock_control <= CPU_CLK_RST;
      regs.sub_oscillator_mode <= ZERO8;
      regs.subclock_control <= ZERO8;
      regs.osc_settle_select <= SETTLE_SEL_RST;
      regs.wide_timer_count <= ZERO16;
      regs.wide_timer_compare <= ONES16;
      regs.narrow_timer_count <= ZERO8;
      regs.timer_control <= ZERO8;
      regs.watch_control <= ZERO8;
      regs.watchdog_control <= ZERO8;
      regs.serial_mode <= ZERO8;
      regs.serial_status <= ZERO8;
      regs.serial_baud <= ZERO8;
      regs.serial_tx_shifter <= ONES8;
      regs.adc_result <= ZERO16;
      regs.adc_mode_reg <= ZERO8;
      regs.adc_channel_select <= ZERO8;
      regs.port_latch <= ZERO8;
      regs.port_direction_reg <= ONES8;
      regs.port_pullup_option <= ZERO8;
    end else if (in_reset) begin
      // system reset reloads the same values
      regs.processor_status_word <= PSW_RST;
      regs.cpu_clock_control <= CPU_CLK_RST;
      regs.sub_oscillator_mode <= ZERO8;
      regs.subclock_control <= ZERO8;
      regs.osc_settle_select <= SETTLE_SEL_RST;
      regs.wide_timer_count <= ZERO16;
      regs.wide_timer_compare <= ONES16;
      regs.narrow_timer_count <= ZERO8;
      regs.timer_control <= ZERO8;
      regs.watch_control <= ZERO8;
      regs.watchdog_control <= ZERO8;
      regs.serial_mode <= ZERO8;
      regs.serial_status <= ZERO8;
      regs.serial_baud <= ZERO8;
      regs.serial_tx_shifter <= ONES8;
      regs.adc_result <= ZERO16;
      regs.adc_mode_reg <= ZERO8;
      regs.adc_channel_select <= ZERO8;
      regs.port_latch <= ZERO8;
      regs.port_direction_reg <= ONES8;
      regs.port_pullup_option <= ZERO8;
    end else if (wr_en) begin
      case (paddr)
        OFF_SETTLE: regs.osc_settle_select <= pwdata[2:0];
        OFF_PSW: regs.processor_status_word <= pwdata[7:0];
        OFF_CLK: begin
          regs.cpu_clock_control <= pwdata[7:0];
          regs.sub_oscillator_mode <= pwdata[15:8];
          regs.subclock_control <= pwdata[23:16];
        end
        OFF_WTIMER: regs.wide_timer_compare <= pwdata[15:0];
        OFF_SERIAL: regs.serial_tx_shifter <= pwdata[7:0];
        OFF_ADC: begin
          regs.adc_mode_reg <= pwdata[7:0];
          regs.adc_channel_select <= pwdata[15:8];
        end
        OFF_PORT: begin
          regs.port_latch <= pwdata[7:0]; // held otherwise
          regs.port_direction_reg <= pwdata[15:8];
          regs.port_pullup_option <= pwdata[23:16];
        end
        default: regs.port_latch <= regs.port_latch;
      endcase
    end
  end

  // port latch out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) port_latch_out <= ZERO8;
    else port_latch_out <= regs.port_latch;
  end

  // apb read and answer: zero wait, error on unmapped
  // read data is captured in setup so it stands through access
  logic mapped;
  always_comb begin
    case (paddr)
      OFF_CTRL, OFF_SETTLE, OFF_STATUS, OFF_VECTOR, OFF_PSW, OFF_CLK,
      OFF_WTIMER, OFF_SERIAL, OFF_ADC, OFF_PORT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= 32'h0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          OFF_CTRL: prdata <= {30'h0, state == SBR_STOP,
            state == SBR_HALT};
          OFF_SETTLE: prdata <= {29'h0, regs.osc_settle_select};
          OFF_STATUS: prdata <= {24'h0, 3'h0, was_stop, wake_by_rst,
            3'(state)};
          OFF_VECTOR: prdata <= {16'h0, vector_addr};
          OFF_PSW: prdata <= {24'h0, regs.processor_status_word};
          OFF_CLK: prdata <= {8'h0, regs.subclock_control,
            regs.sub_oscillator_mode, regs.cpu_clock_control};
          OFF_WTIMER: prdata <= {regs.wide_timer_compare,
            regs.wide_timer_count};
          OFF_SERIAL: prdata <= {regs.serial_baud, regs.serial_status,
            regs.serial_mode, regs.serial_tx_shifter};
          OFF_ADC: prdata <= {regs.adc_channel_select,
            regs.adc_mode_reg, regs.adc_result};
          OFF_PORT: prdata <= {8'h0, regs.port_pullup_option,
            regs.port_direction_reg, regs.port_latch};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end
endmodule : sbr_ctrl

/* File: testbench/sbr_ctrl_props.sv */
// port checker for the standby release and reset sequencer
// bound to every sbr_ctrl instance; one clock domain, pclk
`timescale 1ns/1ns
module sbr_ctrl_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_run,
  input wire logic osc_enable,
  input wire logic pins_hiz,
  input wire logic sys_reset,
  input wire logic [1:0] wake_action,
  input wire logic [15:0] vector_addr
);
  // all checks on pclk, quiet while presetn is low
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // slave answers in the cycle after setup
  a_apb_zero_wait: assert property (psel && !penable |=> pready)
    else $error("pready missing in access phase");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_hiz_in_reset: assert property (sys_reset |-> pins_hiz)
    else $error("pins driven during reset");
  a_reset_halts_cpu: assert property (sys_reset |-> !cpu_run)
    else $error("cpu runs during reset");
  a_stop_cpu_off: assert property (!osc_enable |-> !cpu_run)
    else $error("cpu runs with oscillator stopped");
  a_vector_base: assert property (vector_addr == 16'h0000)
    else $error("reset vector not at base");
  a_run_pins_driven: assert property (cpu_run |-> !pins_hiz)
    else $error("pins float while cpu runs");
  a_fetch_reset: assert property (wake_action == 2'h3 |-> sys_reset)
    else $error("vector fetch outside reset exit");
  a_wake_single: assert property (wake_action != 2'h0 |=> wake_action == 2'h0)
    else $error("wake action longer than one cycle");
  a_vector_run: assert property (wake_action == 2'h3 |=> cpu_run)
    else $error("cpu idle after vector fetch");
endmodule : sbr_ctrl_props

bind sbr_ctrl sbr_ctrl_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .cpu_run(cpu_run), .osc_enable(osc_enable), .pins_hiz(pins_hiz),
  .sys_reset(sys_reset), .wake_action(wake_action),
  .vector_addr(vector_addr));

/* File: testbench/sbr_cpu_model.sv */
// cpu core model that executes halt and stop instructions
// assumes the bench asks for one instruction per one-cycle request
`timescale 1ns/1ns
module sbr_cpu_model (
  input wire logic pclk,
  input wire logic cpu_run,
  input wire logic do_halt,
  input wire logic do_stop,
  output logic halt_exec,
  output logic stop_exec
);
  // instructions execute only while the core is allowed to run
  always_ff @(posedge pclk) begin
    halt_exec <= do_halt & cpu_run;
    stop_exec <= do_stop & cpu_run;
  end
endmodule : sbr_cpu_model

/* File: testbench/sbr_ctrl_test.sv */
// self-checking bench for the standby release and reset sequencer
// assumes short settle counts 16/32/64 and a 4-cycle pin filter
`timescale 1ns/1ns
module sbr_ctrl_test;
  import sbr_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pslverr, pready;
  logic [7:0] paddr, port_latch_out;
  logic [31:0] pwdata, prdata, rd;
  logic reset_pin_n, watchdog_overflow, global_interrupt_enable;
  logic nmi_request, halt_exec, stop_exec, do_halt, do_stop, er;
  logic cpu_run, osc_enable, pins_hiz, sys_reset;
  logic [7:0] irq_request, interrupt_mask_flag;
  logic [1:0] wake_action, act;
  logic [15:0] vector_addr;
  int error_cnt, tests_run, cyc, n;
  // reset-value rows: offset, expected word, expected error
  logic [7:0] r_a [9] = '{OFF_SETTLE, OFF_PSW, OFF_CLK, OFF_WTIMER,
    OFF_SERIAL, OFF_ADC, OFF_PORT, OFF_VECTOR, 8'h40};
  logic [31:0] r_d [9] = '{32'h4, 32'h2, 32'h2, 32'hffff0000,
    32'hff, 32'h0, 32'hff00, 32'h0, 32'h0};
  logic r_e [9] = '{0, 0, 0, 0, 0, 0, 0, 0, 1};
  // halt rows: mask, enable, nmi, expected action
  logic h_m [4] = '{0, 0, 1, 1};
  logic h_i [4] = '{0, 1, 1, 0};
  logic h_n [4] = '{0, 0, 0, 1};
  logic [1:0] h_x [4] = '{2'h1, 2'h2, 2'h0, 2'h2};
  logic [2:0] s_c [3] = '{SEL_12, SEL_15, SEL_17};
  int s_x [3] = '{16, 32, 64};
  sbr_ctrl #(.SETTLE_CYC_12(16), .SETTLE_CYC_15(32), .SETTLE_CYC_17(64),
    .RST_PIN_CYC(4)) u_dut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reset_pin_n(reset_pin_n),
    .watchdog_overflow(watchdog_overflow), .irq_request(irq_request),
    .interrupt_mask_flag(interrupt_mask_flag),
    .global_interrupt_enable(global_interrupt_enable),
    .nmi_request(nmi_request), .halt_exec(halt_exec),
    .stop_exec(stop_exec), .cpu_run(cpu_run), .osc_enable(osc_enable),
    .pins_hiz(pins_hiz), .sys_reset(sys_reset),
    .wake_action(wake_action), .vector_addr(vector_addr),
    .port_latch_out(port_latch_out));
  sbr_cpu_model u_cpu (.pclk(pclk), .cpu_run(cpu_run), .do_halt(do_halt),
    .do_stop(do_stop), .halt_exec(halt_exec), .stop_exec(stop_exec));
  // 100 MHz clock
  always #5 pclk = ~pclk;
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  // one compare, counted
  task automatic chk(input logic [31:0] g, input logic [31:0] x,
    input string m);
    tests_run++;
    if (g !== x) begin
      error_cnt++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  // apb transfer held until pready is sampled
  task automatic apb(input logic [7:0] a, input logic w,
    input logic [31:0] d);
    @(posedge pclk);
    paddr <= a; pwrite <= w; pwdata <= d; psel <= 1; penable <= 0;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  // one instruction request to the cpu model
  task automatic cpu(input logic h, input logic s);
    @(posedge pclk);
    do_halt <= h; do_stop <= s;
    @(posedge pclk);
    do_halt <= 0; do_stop <= 0;
  endtask : cpu
  // wait a bounded time for a wake action pulse
  task automatic wake(input int lim);
    act = 0; n = 0;
    while (n < lim && act == 0) begin
      // reads the value that stood in the cycle before this edge
      @(posedge pclk);
      act = wake_action;
      n++;
    end
  endtask : wake
  // pin reset pulse of a given length in cycles
  task automatic pin(input int len);
    @(posedge pclk) reset_pin_n <= 0;
    repeat (len) @(posedge pclk);
    reset_pin_n <= 1;
  endtask : pin
  // verdict and end of run
  task automatic close_out();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; reset_pin_n = 1; watchdog_overflow = 0;
    irq_request = 8'h02; interrupt_mask_flag = 8'hfe; nmi_request = 0;
    global_interrupt_enable = 0; do_halt = 0; do_stop = 0;
    error_cnt = 0; tests_run = 0; cyc = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1;
    wake(200);
    chk(act, 3, "power-up vector");
    chk(n >= 32 && n <= 40, 1, "power-up settle");
    for (int i = 0; i < 9; i++) begin
      apb(r_a[i], 0, 0);
      chk(rd, r_d[i], "reset value");
      chk(er, r_e[i], "error flag");
    end
    for (int i = 0; i < 4; i++) begin
      cpu(1, 0);
      repeat (3) @(posedge pclk);
      chk({cpu_run, osc_enable}, 2'b01, "halt state");
      interrupt_mask_flag[0] <= h_m[i];
      global_interrupt_enable <= h_i[i];
      nmi_request <= h_n[i];
      irq_request[0] <= 1;
      wake(10);
      chk(act, h_x[i], "halt wake action");
      irq_request[0] <= 0;
      nmi_request <= 0;
    end
    interrupt_mask_flag[0] <= 0;
    global_interrupt_enable <= 1;
    for (int i = 0; i < 3; i++) begin
      apb(OFF_SETTLE, 1, {29'h0, s_c[i]});
      cpu(0, 1);
      wake(20);
      chk({act, osc_enable, cpu_run}, 0, "stop held");
      irq_request[0] <= 1;
      wake(200);
      chk(act, 2, "stop wake action");
      chk(n >= s_x[i] && n <= s_x[i] + 4, 1, "settle count");
      irq_request[0] <= 0;
    end
    // one edge apart from the last release of the request
    @(posedge pclk);
    global_interrupt_enable <= 0;
    irq_request[0] <= 1;
    cpu(0, 1);
    wake(200);
    chk(act, 1, "pending stop wake");
    chk(n >= 62 && n <= 70, 1, "pending stop settle");
    irq_request[0] <= 0;
    pin(2);
    repeat (8) @(posedge pclk);
    chk(sys_reset, 0, "short pin pulse ignored");
    cpu(1, 0);
    pin(12);
    chk({sys_reset, pins_hiz}, 2'b11, "pin reset in halt");
    wake(200);
    chk(act, 3, "pin reset vector");
    // stop ended by the pin: settle first, latch kept, pins float
    apb(OFF_PORT, 1, 32'h0000005a);
    repeat (2) @(posedge pclk);
    chk(port_latch_out, 8'h5a, "port latch written");
    cpu(0, 1);
    repeat (4) @(posedge pclk);
    chk({osc_enable, cpu_run, port_latch_out}, 10'h05a, "stop latch");
    pin(12);
    chk({sys_reset, pins_hiz}, 2'b01, "stop reset floats");
    wake(200);
    chk(act, 3, "stop reset vector");
    chk(n >= 84 && n <= 100, 1, "stop reset settle");
    chk(port_latch_out, 8'h5a, "stop reset keeps latch");
    @(posedge pclk) watchdog_overflow <= 1;
    repeat (6) @(posedge pclk);
    chk({sys_reset, pins_hiz, cpu_run}, 3'b110, "watchdog reset");
    watchdog_overflow <= 0;
    wake(200);
    chk(act, 3, "watchdog vector");
    chk(n >= 32 && n <= 40, 1, "watchdog settle");
    chk(port_latch_out, 8'h00, "port latch cleared");
    apb(OFF_PORT, 0, 0);
    chk(rd, 32'h0000ff00, "port regs reset");
    close_out();
  end
endmodule : sbr_ctrl_test
